//--- core/spi_front_defs.vh
// Constants for the serial command front end.
`ifndef SPI_FRONT_DEFS_VH
`define SPI_FRONT_DEFS_VH
`define OP_SET_LATCH    8'h06
`define OP_CLR_LATCH    8'h04
`define OP_RD_CONFIG    8'h05
`define OP_WR_CONFIG    8'h01
`define OP_RD_MEM       8'h03
`define OP_WR_MEM       8'h02
`define OP_RD_COMP      8'h13
`define OP_WR_COMP      8'h12
`define CFG_RESET       8'h40
`define CFG_BP0_BIT     2
`define CFG_BP1_BIT     3
`define CFG_LATCH_BIT   1
`define ADDR_BITS       15
`endif

//--- core/spi_slave_command_frontend.v
// Serial slave command front end: framing, opcode decode, config byte, write latch.
`timescale 1ns/100ps
`include "spi_front_defs.vh"
// Contract
// (R1) Sample input on each serial clock rise.
// (R2) Change output data on serial clock falls.
// (R3) First byte is opcode, then address, data.
// (R4) Master deselects between commands, one opcode each.
// (R5) Deselected: ignore input, output undriven.
// (R6) All bytes travel most significant bit first.
// (R7) Two-byte address, uppermost bit ignored; the companion commands here take a single address byte.
// (R8) Master should send unused address bit zero.
// (R9) Unknown opcode: ignore rest, output undriven.
// (R10) Clock level at select picks mode 0/3.
// (R11) Mode 3: skip first fall, count rises.
// (R12) Master idles clock per chosen mode.
// (R13) Master keeps clock at or below maximum.
// (R14) Only master starts transactions; device responds.
// (R15) Eight-bit config register via serial commands.
// (R16) Master may tie input and output together.
// (R17) Decode eight fixed opcodes.
// (R18) Latch clears at deselect after write commands.
// (R19) Bit counter resets at select; bytes per eight.
module spi_slave_command_frontend
(
  // System
  input  wire        CLK_SYS,
  input  wire        RST,
  // Serial link
  input  wire        CS_N,
  input  wire        SCK,
  input  wire        SI,
  output reg         SO_O,
  output reg         SO_OE,
  // Back end
  output reg         MODE3,
  output reg  [7:0]  OPCODE,
  output reg         OPCODE_VALID,
  output reg  [14:0] ADDR,
  output reg         ADDR_VALID,
  output reg  [7:0]  WDATA,
  output reg         WDATA_VALID,
  output reg         RDATA_REQ,
  input  wire [7:0]  RDATA,
  output wire [7:0]  CONFIG_BYTE,
  output wire        WRITE_PERMIT
);
  // ==========================================================================
  // Input synchronisers
  reg [1:0] cs_s_q;
  reg [1:0] sck_s_q;
  reg [1:0] si_s_q;
  reg       cs_d1_q;
  reg       sck_d1_q;
  always @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      cs_s_q   <= 2'h3;
      sck_s_q  <= 2'h0;
      si_s_q   <= 2'h0;
      cs_d1_q  <= 1'b1;
      sck_d1_q <= 1'b0;
    end
    else
    begin
      cs_s_q   <= {cs_s_q[0], CS_N};
      sck_s_q  <= {sck_s_q[0], SCK};
      si_s_q   <= {si_s_q[0], SI};
      cs_d1_q  <= cs_s_q[1];
      sck_d1_q <= sck_s_q[1];
    end
  end
  wire cs_n_s   = cs_s_q[1];
  wire sck_s    = sck_s_q[1];
  wire si_s     = si_s_q[1];
  wire cs_fall  = cs_d1_q & ~cs_n_s;
  wire cs_rise  = ~cs_d1_q & cs_n_s;
  wire sck_rise = ~sck_d1_q & sck_s;
  wire sck_fall = sck_d1_q & ~sck_s;

  // ==========================================================================
  // Frame state: one-hot.
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_OP   = 5'h02;
  localparam [4:0] ST_ADDR = 5'h04;
  localparam [4:0] ST_DATA = 5'h08;
  localparam [4:0] ST_DEAD = 5'h10;

  reg [4:0]  state_q;
  reg [2:0]  bit_q;
  reg [7:0]  shin_q;
  reg [7:0]  shout_q;
  reg        abyte_q;
  reg [7:0]  ahi_q;
  reg [7:0]  cfg_q;
  reg        latch_q;
  reg        wr_cmd_q;
  reg        rd_q;
  wire [7:0] byte_in = {shin_q[6:0], si_s};  // (R6)
  wire       byte_done = sck_rise & (bit_q == 3'h7);  // (R19)

  function is_known;
    input [7:0] op;
    begin
      case (op)  // (R17)
        `OP_SET_LATCH, `OP_CLR_LATCH, `OP_RD_CONFIG, `OP_WR_CONFIG,
        `OP_RD_MEM, `OP_WR_MEM, `OP_RD_COMP, `OP_WR_COMP: is_known = 1'b1;
        default: is_known = 1'b0;
      endcase
    end
  endfunction

  function has_addr;
    input [7:0] op;
    begin
      has_addr = (op == `OP_RD_MEM) | (op == `OP_WR_MEM) |
                 (op == `OP_RD_COMP) | (op == `OP_WR_COMP);
    end
  endfunction

  assign CONFIG_BYTE  = {1'b0, 1'b1, 2'h0, cfg_q[3:2], latch_q, 1'b0};  // (R15)
  assign WRITE_PERMIT = latch_q;

  // ==========================================================================
  // Opcode classes of the command held for this frame.
  wire op_mem_rd  = (OPCODE == `OP_RD_MEM);
  wire op_mem_wr  = (OPCODE == `OP_WR_MEM);
  wire op_comp_rd = (OPCODE == `OP_RD_COMP);
  wire op_comp_wr = (OPCODE == `OP_WR_COMP);

  // ==========================================================================
  // Decode of the byte being completed. Write commands are gathered here so
  // that the latch clearing at deselect reads a single flag.
  reg dec_set_latch;
  reg dec_wr_cmd;
  reg dec_rd_cfg;
  always @*
  begin
    dec_set_latch = 1'b0;
    dec_wr_cmd    = 1'b0;
    dec_rd_cfg    = 1'b0;
    case (byte_in)
      `OP_SET_LATCH:
        dec_set_latch = 1'b1;
      `OP_CLR_LATCH, `OP_WR_CONFIG, `OP_WR_MEM, `OP_WR_COMP:
        dec_wr_cmd = 1'b1;  // (R18)
      `OP_RD_CONFIG:
        dec_rd_cfg = 1'b1;
      default:
        dec_set_latch = 1'b0;
    endcase
  end

  // ==========================================================================
  // Frame sequencing. The device never starts anything by itself: every
  // action below is gated by select and by clock edges seen from the master.
  // A frame cut short by select rising simply returns to idle; a partial
  // byte is dropped and never reaches the back end.

  always @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      state_q      <= ST_IDLE;
      bit_q        <= 3'h0;
      shin_q       <= 8'h00;
      shout_q      <= 8'h00;
      abyte_q      <= 1'b0;
      ahi_q        <= 8'h00;
      cfg_q        <= `CFG_RESET;
      latch_q      <= 1'b0;
      wr_cmd_q     <= 1'b0;
      rd_q         <= 1'b0;
      MODE3        <= 1'b0;
      OPCODE       <= 8'h00;
      OPCODE_VALID <= 1'b0;
      ADDR         <= 15'h0000;
      ADDR_VALID   <= 1'b0;
      WDATA        <= 8'h00;
      WDATA_VALID  <= 1'b0;
      RDATA_REQ    <= 1'b0;
      SO_O         <= 1'b0;
      SO_OE        <= 1'b0;
    end
    else
    begin
      OPCODE_VALID <= 1'b0;
      ADDR_VALID   <= 1'b0;
      WDATA_VALID  <= 1'b0;
      RDATA_REQ    <= 1'b0;
      if (cs_n_s)
      begin
        // Deselected: input ignored, output released.
        state_q <= ST_IDLE;  // (R5)
        SO_OE   <= 1'b0;  // (R5)
        rd_q    <= 1'b0;
        if (cs_rise & wr_cmd_q)
          latch_q <= 1'b0;  // (R18)
        wr_cmd_q <= 1'b0;
      end
      else if (cs_fall)
      begin
        // The clock level seen with select decides the mode; in mode 3 the
        // first fall is simply not a rise, so counting rises only is enough.
        MODE3   <= sck_s;  // (R10) (R11)
        bit_q   <= 3'h0;  // (R19)
        state_q <= ST_OP;  // (R3)
        abyte_q <= 1'b0;
      end
      else
      begin
        if (sck_rise && state_q != ST_DEAD && state_q != ST_IDLE)
        begin
          shin_q <= byte_in;  // (R1)
          bit_q  <= bit_q + 3'h1;
        end
        case (state_q)
          ST_OP:
            if (byte_done)
            begin
              OPCODE       <= byte_in;
              OPCODE_VALID <= is_known(byte_in);
              if (!is_known(byte_in))
                state_q <= ST_DEAD;  // (R9)
              else if (has_addr(byte_in))
                state_q <= ST_ADDR;  // (R3)
              else
                state_q <= ST_DATA;
              if (dec_set_latch)
                latch_q <= 1'b1;
              if (dec_wr_cmd)
                wr_cmd_q <= 1'b1;  // (R18)
              if (dec_rd_cfg)
              begin
                rd_q    <= 1'b1;
                shout_q <= CONFIG_BYTE;
              end
            end
          ST_ADDR:
            if (byte_done)
            begin
              abyte_q <= 1'b1;
              if (!abyte_q)
                ahi_q <= byte_in;
              else
              begin
                // Upper bit of the high byte is dropped.
                ADDR       <= {ahi_q[6:0], byte_in};  // (R7)
                ADDR_VALID <= (OPCODE == `OP_RD_MEM) | (OPCODE == `OP_WR_MEM);
                state_q    <= ST_DATA;
                if (OPCODE == `OP_RD_MEM)
                begin
                  rd_q      <= 1'b1;
                  RDATA_REQ <= 1'b1;
                end
              end
              if (OPCODE == `OP_RD_COMP || OPCODE == `OP_WR_COMP)
              begin
                // Companion commands carry a single address byte.
                ADDR    <= {7'h00, byte_in};
                state_q <= ST_DATA;
                if (OPCODE == `OP_RD_COMP)
                begin
                  rd_q      <= 1'b1;
                  RDATA_REQ <= 1'b1;
                end
              end
            end
          ST_DATA:
            if (byte_done)
            begin
              if (OPCODE == `OP_WR_CONFIG && latch_q)
              begin
                cfg_q[`CFG_BP0_BIT] <= byte_in[`CFG_BP0_BIT];
                cfg_q[`CFG_BP1_BIT] <= byte_in[`CFG_BP1_BIT];
              end
              WDATA       <= byte_in;
              WDATA_VALID <= op_mem_wr | op_comp_wr;
              RDATA_REQ   <= op_mem_rd | op_comp_rd;
            end
          ST_IDLE, ST_DEAD:
            SO_OE <= 1'b0;  // (R9)
          default:
            state_q <= ST_IDLE;
        endcase
        // Output shifts on clock falls, MSB first; the back end answers
        // RDATA_REQ within one cycle, well before the next fall.
        if (RDATA_REQ)
          shout_q <= RDATA;
        if (sck_fall && rd_q && state_q == ST_DATA)
        begin
          SO_O    <= shout_q[7];  // (R2) (R6)
          SO_OE   <= 1'b1;  // (R14)
          shout_q <= {shout_q[6:0], 1'b0};
        end
      end
    end
  end
endmodule

//--- dv/spi_front_chk.sv
// Concurrent checks on the serial command front end ports.
`timescale 1ns/100ps
module spi_front_chk
(
  // Watched ports.
  input wire       CLK_SYS,
  input wire       RST,
  input wire       CS_N,
  input wire       SCK,
  input wire       SO_O,
  input wire       SO_OE,
  input wire       MODE3,
  input wire [7:0] OPCODE,
  input wire       OPCODE_VALID,
  input wire       ADDR_VALID,
  input wire       RDATA_REQ,
  input wire [7:0] CONFIG_BYTE,
  input wire       WRITE_PERMIT
);
  // ====
  // Checks.
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  sequence wr_end;
    $rose(CS_N) && (OPCODE inside {8'h01, 8'h02, 8'h04, 8'h12});
  endsequence
  sequence latch_cmd;
    OPCODE_VALID && OPCODE == 8'h06;
  endsequence
  a_oe_deselect: assert property (CS_N [*5] |-> !SO_OE)
    else $error("output driven while deselected");
  a_so_hold: assert property ((SCK && SO_OE) [*4] |-> $stable(SO_O))
    else $error("output changed while serial clock high");
  a_mode_hold: assert property ((!CS_N) [*6] |-> $stable(MODE3))
    else $error("mode changed inside a frame");
  a_known_op: assert property (OPCODE_VALID |->
    OPCODE inside {8'h06, 8'h04, 8'h05, 8'h01, 8'h03, 8'h02, 8'h13, 8'h12})
    else $error("unknown opcode flagged valid");
  a_read_req: assert property (RDATA_REQ |-> OPCODE inside {8'h03, 8'h05, 8'h13})
    else $error("read request outside a read");
  a_addr_mem: assert property (ADDR_VALID |-> OPCODE inside {8'h02, 8'h03})
    else $error("address strobe outside a memory command");
  a_latch_set: assert property (latch_cmd |-> ##[0:60] WRITE_PERMIT)
    else $error("latch not set");
  a_latch_clear: assert property (wr_end |-> ##[1:8] !WRITE_PERMIT)
    else $error("latch not cleared at deselect");
  a_cfg_fixed: assert property (CONFIG_BYTE == {4'h4, CONFIG_BYTE[3:2], WRITE_PERMIT, 1'b0})
    else $error("config byte fixed bits wrong");
endmodule
bind spi_slave_command_frontend spi_front_chk i_chk (.CLK_SYS(CLK_SYS), .RST(RST),
  .CS_N(CS_N), .SCK(SCK), .SO_O(SO_O), .SO_OE(SO_OE), .MODE3(MODE3), .OPCODE(OPCODE),
  .OPCODE_VALID(OPCODE_VALID), .ADDR_VALID(ADDR_VALID), .RDATA_REQ(RDATA_REQ),
  .CONFIG_BYTE(CONFIG_BYTE), .WRITE_PERMIT(WRITE_PERMIT));

//--- dv/spi_master_model.sv
// Serial bus master model that frames commands for the front end.
`timescale 1ns/100ps
module spi_master_model
(
  // Serial pins.
  input  wire CLK_SYS,
  output reg  CS_N,
  output reg  SCK,
  output reg  SI,
  input  wire SO_O,
  input  wire SO_OE
);
  reg [7:0] rx_q;
  reg       m3_q;
  initial
  begin
    CS_N = 1'b1;
    SCK  = 1'b0;
    SI   = 1'b0;
  end
  // ====
  // Half of the 160 ns serial period.
  task automatic half;
    repeat (16) @(posedge CLK_SYS);
  endtask
  task automatic start(input reg m3);
    m3_q = m3;
    SCK  <= m3;
    half;
    CS_N <= 1'b0;
    half;
  endtask
  // An undriven output reads as unknown so a missing answer cannot match.
  task automatic xfer(input reg [7:0] tx);
    integer i;
    for (i = 7; i >= 0; i = i - 1)
    begin
      SCK  <= 1'b0;
      SI   <= tx[i];
      half;
      SCK  <= 1'b1;
      rx_q <= {rx_q[6:0], SO_OE ? SO_O : 1'bx};
      half;
    end
  endtask
  task automatic stop;
    SCK  <= m3_q;
    half;
    CS_N <= 1'b1;
    SI   <= ~SI;
    half;
  endtask
endmodule

//--- dv/spi_slave_command_frontend_tb_top.sv
// Self-checking bench for the serial command front end.
`timescale 1ns/100ps
module spi_slave_command_frontend_tb_top;
  reg         clk_sys = 1'b0;
  reg         rst     = 1'b1;
  reg  [7:0]  rdata   = 8'ha5;
  wire        cs_n, sck, si, so_o, so_oe, mode3, op_v, wp;
  wire [7:0]  opcode, wdata, cfg;
  wire [14:0] addr;
  wire        addr_v, wd_v, rd_req;
  integer     av = 0;
  integer     wv = 0;
  integer     rq = 0;
  integer     a0, w0, r0;
  integer     err_total = 0;
  integer     checked   = 0;
  integer     cyc       = 0;
  integer     ops       = 0;
  integer     n;
  always #2.5 clk_sys = ~clk_sys;
  spi_master_model i_master (.CLK_SYS(clk_sys), .CS_N(cs_n), .SCK(sck), .SI(si),
    .SO_O(so_o), .SO_OE(so_oe));
  spi_slave_command_frontend i_dut (.CLK_SYS(clk_sys), .RST(rst), .CS_N(cs_n), .SCK(sck),
    .SI(si), .SO_O(so_o), .SO_OE(so_oe), .MODE3(mode3), .OPCODE(opcode), .OPCODE_VALID(op_v),
    .ADDR(addr), .ADDR_VALID(addr_v), .WDATA(wdata), .WDATA_VALID(wd_v), .RDATA_REQ(rd_req),
    .RDATA(rdata),
    .CONFIG_BYTE(cfg), .WRITE_PERMIT(wp));
  // ====
  // Checking and closing.
  task automatic give_verdict;
    if (err_total == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input [31:0] got, input [31:0] exp);
    checked = checked + 1;
    if (got !== exp)
    begin
      err_total = err_total + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  always @(posedge clk_sys)
  begin
    cyc = cyc + 1;
    if (op_v === 1'b1)
      ops = ops + 1;
    if (addr_v === 1'b1)
      av = av + 1;
    if (wd_v === 1'b1)
      wv = wv + 1;
    if (rd_req === 1'b1)
      rq = rq + 1;
    if (cyc == 30000)
    begin
      err_total = err_total + 1;
      give_verdict;
    end
  end
  // ====
  // Scenarios.
  task automatic t_latch;
    i_master.start(1'b0);
    chk(mode3, 0);
    i_master.xfer(8'h06);
    i_master.stop;
    chk(wp, 1);
    chk(so_oe, 0);
  endtask
  task automatic t_rdcfg;
    i_master.start(1'b1);
    chk(mode3, 1);
    i_master.xfer(8'h05);
    i_master.xfer(8'h00);
    chk(i_master.rx_q, 8'h42);
    i_master.stop;
  endtask
  task automatic t_wrcfg(input [7:0] d);
    i_master.start(1'b0);
    i_master.xfer(8'h01);
    i_master.xfer(d);
    i_master.stop;
    chk(cfg, 8'h4c);
    chk(wp, 0);
  endtask
  task automatic t_mem;
    t_latch;
    a0 = av;
    w0 = wv;
    i_master.start(1'b1);
    i_master.xfer(8'h02);
    i_master.xfer(8'hfa);
    i_master.xfer(8'hbc);
    i_master.xfer(8'h5a);
    i_master.stop;
    chk(addr, 15'h7abc);
    chk(wdata, 8'h5a);
    chk(wp, 0);
    chk(av - a0, 1);
    chk(wv - w0, 1);
    a0 = av;
    r0 = rq;
    rdata <= 8'h3c;
    i_master.start(1'b0);
    i_master.xfer(8'h03);
    i_master.xfer(8'h00);
    i_master.xfer(8'h10);
    i_master.xfer(8'h00);
    chk(i_master.rx_q, 8'h3c);
    i_master.stop;
    chk(addr, 15'h0010);
    chk(av - a0, 1);
    chk(rq - r0, 2);
  endtask
  task automatic t_bad;
    n = ops;
    i_master.start(1'b0);
    i_master.xfer(8'hff);
    i_master.xfer(8'h06);
    i_master.xfer(8'h00);
    chk(i_master.rx_q, 8'hxx);
    chk(so_oe, 0);
    i_master.stop;
    chk(ops - n, 0);
    t_latch;
  endtask
  initial
  begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    t_latch;
    t_rdcfg;
    t_wrcfg(8'h8f);
    t_wrcfg(8'h00);
    t_mem;
    t_bad;
    give_verdict;
  end
endmodule
